// [rtl/ohs_sequencer.sv]
// Overcurrent hiccup sequencer for a multi-phase core and a single-phase north-bridge buck.
// Assumes synchronous inputs, PWM requests from the modulator, and soft-start done from ramp logic.
// Summary of operation
// - Shutdown: gates low, ext pwm hi-z, power-good low
// - Hold drives off for 12 ms
// - Retry soft-start only if still enabled
// - Repeat hiccup up to seven retries, eight attempts total
// - Fault on final core retry latches both off
// - Trip level raised 1.4x during soft-start
// - Clean soft-start clears retry counter
// - Nominal level after soft-start; retrip allowed
// - NB fault shuts only NB drives
// - Seven failed NB retries latch both off
// - Power-save core trip uses single phase
// - Restart after power-save fault in normal mode
// - Channel over limit: upper low, lower high
// - Upper held low until channel current drops
// - Averaged current above 100 uA per active phase trips protection
`timescale 1ns/1ps

module ohs_sequencer
    import ohs_pkg::*;
#(
    parameter int unsigned WAIT_COUNT = WAIT_CYCLES
) (
    input  wire logic                       i_ref_clk,
    input  wire logic                       i_rst,
    input  wire logic                       i_enable,
    input  wire logic                       i_power_save_select_n,
    input  wire logic                       i_ext_phases_active,
    input  wire logic                       i_core_soft_done,
    input  wire logic                       i_nb_soft_done,
    input  wire logic [CUR_W-1:0]           i_core_avg_ua,
    input  wire logic [CUR_W-1:0]           i_nb_avg_ua,
    input  wire logic [CUR_W*CORE_CHANNELS-1:0] i_chan_ua,
    input  wire logic [CORE_CHANNELS-1:0]   i_core_pwm,
    input  wire logic                       i_nb_pwm,
    output logic [CORE_CHANNELS-1:0]        o_upper_gate_drive,
    output logic [CORE_CHANNELS-1:0]        o_lower_gate_drive,
    output logic                            o_nb_upper_gate_drive,
    output logic                            o_nb_lower_gate_drive,
    output logic [1:0]                      o_ext_pwm_oe,
    output logic                            o_power_good_out,
    output logic                            o_core_soft_start,
    output logic                            o_nb_soft_start,
    output logic                            o_power_save_active,
    output logic                            o_latched_off
);

    localparam logic [22:0] WAIT_LAST = 23'(WAIT_COUNT - 1);

    ohs_state_type core_r;
    ohs_state_type core_nxt;
    ohs_state_type nb_r;
    ohs_state_type nb_nxt;
    logic [22:0]   core_cnt_r;
    logic [22:0]   nb_cnt_r;
    logic [3:0]    core_retry_r;
    logic [3:0]    nb_retry_r;
    logic          psave_r;
    logic          psave_nxt;
    logic [CORE_CHANNELS-1:0] ocl_r;
    logic [CUR_W+1:0]         core_limit;
    logic          core_trip;
    logic          nb_trip;
    logic          core_wait_end;
    logic          nb_wait_end;
    logic          latch_now;
    ohs_gate_type  gate_nxt;

    // Trip thresholds; core limit scales with active phase count
    always_comb begin
        logic [CUR_W-1:0] base;
        logic [2:0]       phases;
        base   = (core_r == OHS_SOFT) ? OCP_SS_UA : OCP_NOM_UA;
        phases = psave_r ? 3'd1 : (i_ext_phases_active ? 3'd4 : 3'd2);
        core_limit = (CUR_W+2)'(base * phases);
    end

    assign core_trip = ({2'b00, i_core_avg_ua} > core_limit);
    assign nb_trip   = (i_nb_avg_ua > ((nb_r == OHS_SOFT) ? OCP_SS_UA : OCP_NOM_UA));
    assign core_wait_end = (core_r == OHS_WAIT) && (core_cnt_r == WAIT_LAST);
    assign nb_wait_end   = (nb_r == OHS_WAIT) && (nb_cnt_r == WAIT_LAST);
    // Final attempt: fault again once seven retries are used
    assign latch_now = ((core_r == OHS_SOFT || core_r == OHS_RUN) && core_trip
                        && core_retry_r == 4'(RETRY_MAX))
                     || ((nb_r == OHS_SOFT || nb_r == OHS_RUN) && nb_trip
                        && nb_retry_r == 4'(RETRY_MAX));

    // Core sequencer
    always_comb begin
        core_nxt = core_r;
        case (core_r)
            OHS_OFF: begin
                if (i_enable) begin
                    core_nxt = OHS_SOFT;
                end
            end
            OHS_SOFT: begin
                if (core_trip) begin
                    core_nxt = OHS_WAIT;
                end else if (i_core_soft_done) begin
                    core_nxt = OHS_RUN;
                end
            end
            OHS_RUN: begin
                if (core_trip) begin
                    core_nxt = OHS_WAIT;
                end else if (!i_enable) begin
                    core_nxt = OHS_OFF;
                end
            end
            OHS_WAIT: begin
                if (core_wait_end) begin
                    core_nxt = i_enable ? OHS_SOFT : OHS_OFF;
                end
            end
            OHS_LATCHED: begin
                core_nxt = OHS_LATCHED;
            end
            default: begin
                core_nxt = OHS_OFF;
            end
        endcase
        if (latch_now) begin
            core_nxt = OHS_LATCHED;
        end
    end

    // North-bridge sequencer, same hiccup flow on its own drives
    always_comb begin
        nb_nxt = nb_r;
        case (nb_r)
            OHS_OFF: begin
                if (i_enable) begin
                    nb_nxt = OHS_SOFT;
                end
            end
            OHS_SOFT: begin
                if (nb_trip) begin
                    nb_nxt = OHS_WAIT;
                end else if (i_nb_soft_done) begin
                    nb_nxt = OHS_RUN;
                end
            end
            OHS_RUN: begin
                if (nb_trip) begin
                    nb_nxt = OHS_WAIT;
                end else if (!i_enable) begin
                    nb_nxt = OHS_OFF;
                end
            end
            OHS_WAIT: begin
                if (nb_wait_end) begin
                    nb_nxt = i_enable ? OHS_SOFT : OHS_OFF;
                end
            end
            OHS_LATCHED: begin
                nb_nxt = OHS_LATCHED;
            end
            default: begin
                nb_nxt = OHS_OFF;
            end
        endcase
        if (latch_now) begin
            nb_nxt = OHS_LATCHED;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            core_r <= OHS_OFF;
            nb_r   <= OHS_OFF;
        end else begin
            core_r <= core_nxt;
            nb_r   <= nb_nxt;
        end
    end

    // Shutdown wait timers
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || core_r != OHS_WAIT) begin
            core_cnt_r <= '0;
        end else if (!core_wait_end) begin
            core_cnt_r <= core_cnt_r + 23'd1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst || nb_r != OHS_WAIT) begin
            nb_cnt_r <= '0;
        end else if (!nb_wait_end) begin
            nb_cnt_r <= nb_cnt_r + 23'd1;
        end
    end

    // Retry counters: bump on each retry, clear on clean start
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            core_retry_r <= RETRY_RESET;
        end else if (core_wait_end && i_enable) begin
            core_retry_r <= core_retry_r + 4'd1;
        end else if (core_r == OHS_SOFT && core_nxt == OHS_RUN) begin
            core_retry_r <= RETRY_RESET;
        end
    end

    // North-bridge retries count apart from the core
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            nb_retry_r <= RETRY_RESET;
        end else if (nb_wait_end && i_enable) begin
            nb_retry_r <= nb_retry_r + 4'd1;
        end else if (nb_r == OHS_SOFT && nb_nxt == OHS_RUN) begin
            nb_retry_r <= RETRY_RESET;
        end
    end

    // Power-save level only while running; any trip, stop or restart returns to normal
    always_comb begin
        psave_nxt = 1'b0;
        if (core_r == OHS_RUN) begin
            psave_nxt = !i_power_save_select_n && !core_trip;
        end
    end

    // Status output takes the same next value so it always matches the level in use
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            psave_r <= 1'b0;
        end else begin
            psave_r <= psave_nxt;
        end
    end

    // Per-channel current limit
    genvar ch;
    generate
        for (ch = 0; ch < CORE_CHANNELS; ch++) begin : g_ocl
            // Over-limit state holds while the channel sits exactly at the reference
            always_ff @(posedge i_ref_clk) begin
                if (i_rst) begin
                    ocl_r[ch] <= 1'b0;
                end else if (i_chan_ua[ch*CUR_W +: CUR_W] > OCL_REF_UA) begin
                    ocl_r[ch] <= 1'b1;
                end else if (i_chan_ua[ch*CUR_W +: CUR_W] < OCL_REF_UA) begin
                    ocl_r[ch] <= 1'b0;
                end
            end
            always_comb begin
                logic over;
                over = ocl_r[ch] || (i_chan_ua[ch*CUR_W +: CUR_W] > OCL_REF_UA);
                gate_nxt.upper[ch] = i_core_pwm[ch] && !over;
                gate_nxt.lower[ch] = !i_core_pwm[ch] || over;
            end
        end
    endgenerate

    // Registered drive outputs
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_upper_gate_drive    <= '0;
            o_lower_gate_drive    <= '0;
            o_nb_upper_gate_drive <= 1'b0;
            o_nb_lower_gate_drive <= 1'b0;
            o_ext_pwm_oe          <= 2'b00;
            o_power_good_out      <= 1'b0;
        end else begin
            if (core_nxt == OHS_SOFT || core_nxt == OHS_RUN) begin
                o_upper_gate_drive <= gate_nxt.upper;
                o_lower_gate_drive <= gate_nxt.lower;
                o_ext_pwm_oe       <= {2{i_ext_phases_active}};
            end else begin
                o_upper_gate_drive <= '0;
                o_lower_gate_drive <= '0;
                o_ext_pwm_oe       <= 2'b00;
            end
            if (nb_nxt == OHS_SOFT || nb_nxt == OHS_RUN) begin
                o_nb_upper_gate_drive <= i_nb_pwm;
                o_nb_lower_gate_drive <= !i_nb_pwm;
            end else begin
                o_nb_upper_gate_drive <= 1'b0;
                o_nb_lower_gate_drive <= 1'b0;
            end
            o_power_good_out <= (core_nxt == OHS_RUN) && (nb_nxt == OHS_RUN);
        end
    end

    // Status
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_core_soft_start   <= 1'b0;
            o_nb_soft_start     <= 1'b0;
            o_power_save_active <= 1'b0;
            o_latched_off       <= 1'b0;
        end else begin
            o_core_soft_start   <= (core_nxt == OHS_SOFT);
            o_nb_soft_start     <= (nb_nxt == OHS_SOFT);
            o_power_save_active <= psave_nxt;
            o_latched_off       <= (core_nxt == OHS_LATCHED);
        end
    end

endmodule : ohs_sequencer

// [inc/ohs_pkg.sv]
// Package for the overcurrent hiccup sequencer: timing counts, limits, states, carriers.
// Assumes a single 20 MHz reference clock.
package ohs_pkg;

    localparam int unsigned CLK_HZ         = 20_000_000;
    localparam int unsigned WAIT_MS        = 12;
    localparam int unsigned WAIT_CYCLES    = (WAIT_MS * (CLK_HZ / 1000));
    localparam int unsigned RETRY_MAX      = 7;
    localparam int unsigned CORE_CHANNELS  = 4;
    localparam int unsigned CUR_W          = 12;
    // Currents are in units of 1 uA
    localparam logic [CUR_W-1:0] OCP_NOM_UA  = 12'h064;
    localparam logic [CUR_W-1:0] OCP_SS_UA   = 12'h08C;
    localparam logic [CUR_W-1:0] OCL_REF_UA  = 12'h08C;
    localparam logic [3:0]       RETRY_RESET = 4'h0;

    typedef enum logic [4:0] {
        OHS_OFF      = 5'b00001,
        OHS_SOFT     = 5'b00010,
        OHS_RUN      = 5'b00100,
        OHS_WAIT     = 5'b01000,
        OHS_LATCHED  = 5'b10000
    } ohs_state_type;

    typedef struct packed {
        logic [CORE_CHANNELS-1:0] upper;
        logic [CORE_CHANNELS-1:0] lower;
    } ohs_gate_type;

endpackage : ohs_pkg

// [dv/ohs_seq_monitor.sv]
// Checker for the hiccup sequencer: trip response, wait, retry and channel limiting.
// Assumes it is bound to ohs_sequencer and sees its ports only.
`timescale 1ns/1ps
module ohs_seq_monitor
    import ohs_pkg::*;
#(
    parameter int unsigned WAIT_COUNT = WAIT_CYCLES
) (
    input wire logic                           i_ref_clk,
    input wire logic                           i_rst,
    input wire logic                           i_enable,
    input wire logic                           i_ext_phases_active,
    input wire logic [CUR_W-1:0]               i_core_avg_ua,
    input wire logic [CUR_W-1:0]               i_nb_avg_ua,
    input wire logic [CUR_W*CORE_CHANNELS-1:0] i_chan_ua,
    input wire logic [CORE_CHANNELS-1:0]       o_upper_gate_drive,
    input wire logic [CORE_CHANNELS-1:0]       o_lower_gate_drive,
    input wire logic                           o_nb_upper_gate_drive,
    input wire logic                           o_nb_lower_gate_drive,
    input wire logic [1:0]                     o_ext_pwm_oe,
    input wire logic                           o_power_good_out,
    input wire logic                           o_core_soft_start,
    input wire logic                           o_power_save_active,
    input wire logic                           o_latched_off
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    logic [CUR_W-1:0] core_lim;
    logic             core_trip;
    logic             trip_seen_r;
    logic [19:0]      wait_cnt_r;
    // Nominal level times the phase count in use
    assign core_lim = o_power_save_active ? 12'h064 : (i_ext_phases_active ? 12'h190 : 12'h0C8);
    assign core_trip = o_power_good_out && (i_core_avg_ua > core_lim);
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || core_trip) wait_cnt_r <= '0;
        else if (wait_cnt_r != '1) wait_cnt_r <= wait_cnt_r + 1'b1;
    end
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || o_core_soft_start) trip_seen_r <= 1'b0;
        else if (core_trip) trip_seen_r <= 1'b1;
    end
    chk_trip_drives_off: assert property (core_trip |=>
        (o_upper_gate_drive | o_lower_gate_drive) == '0 && o_ext_pwm_oe == '0 && !o_power_good_out)
        else $error("drives not off after trip");
    chk_wait_held_off: assert property (trip_seen_r && wait_cnt_r < WAIT_COUNT - 2 |->
        (o_upper_gate_drive | o_lower_gate_drive) == '0 && !o_core_soft_start)
        else $error("drives on during wait");
    chk_retry_timing: assert property ($rose(o_core_soft_start) && trip_seen_r |->
        wait_cnt_r >= WAIT_COUNT - 2 && $past(i_enable)) else $error("early retry");
    chk_soft_raised: assert property (o_core_soft_start && i_enable &&
        i_nb_avg_ua <= 12'h064 && i_core_avg_ua <= (i_ext_phases_active ? 12'h230 : 12'h118)
        |=> o_upper_gate_drive[0] || o_lower_gate_drive[0]) else $error("soft-start tripped");
    chk_soft_normal: assert property (o_core_soft_start |-> !o_power_save_active)
        else $error("power-save level in soft-start");
    chk_chan_limit: assert property (o_power_good_out && !core_trip && i_enable &&
        i_chan_ua[CUR_W-1:0] > OCL_REF_UA |=> !o_upper_gate_drive[0] && o_lower_gate_drive[0])
        else $error("channel limit not applied");
    chk_chan_hold: assert property ((i_chan_ua[CUR_W-1:0] > OCL_REF_UA) ##1
        (i_chan_ua[CUR_W-1:0] == OCL_REF_UA) |=> !o_upper_gate_drive[0])
        else $error("channel limit released early");
    chk_nb_only: assert property (o_power_good_out && !core_trip && i_enable
        && i_nb_avg_ua > 12'h064
        |=> !o_nb_upper_gate_drive && !o_nb_lower_gate_drive
        && (o_upper_gate_drive[0] || o_lower_gate_drive[0])) else $error("nb trip wrong");
    chk_latch_hold: assert property (o_latched_off |=> o_latched_off &&
        (o_upper_gate_drive | o_lower_gate_drive) == '0 && !o_nb_upper_gate_drive
        && !o_nb_lower_gate_drive && !o_power_good_out) else $error("latch released");
endmodule : ohs_seq_monitor

bind ohs_sequencer ohs_seq_monitor #(.WAIT_COUNT(WAIT_COUNT)) i_mon (.i_ref_clk, .i_rst,
    .i_enable, .i_ext_phases_active, .i_core_avg_ua, .i_nb_avg_ua, .i_chan_ua,
    .o_upper_gate_drive, .o_lower_gate_drive, .o_nb_upper_gate_drive, .o_nb_lower_gate_drive,
    .o_ext_pwm_oe, .o_power_good_out, .o_core_soft_start, .o_power_save_active, .o_latched_off);

// [dv/ohs_drv_model.sv]
// Gate driver and inductor model: turns core gate drives into per-channel currents.
// Assumes one current step per clock; the current holds while both switches are off.
`timescale 1ns/1ps
module ohs_drv_model
    import ohs_pkg::*;
#(
    parameter logic [CUR_W-1:0] STEP = 12'h023
) (
    input  wire logic                           i_ref_clk,
    input  wire logic                           i_rst,
    input  wire logic [CORE_CHANNELS-1:0]       i_upper,
    input  wire logic [CORE_CHANNELS-1:0]       i_lower,
    output logic      [CUR_W*CORE_CHANNELS-1:0] o_chan_ua
);
    always_ff @(posedge i_ref_clk) begin
        for (int c = 0; c < CORE_CHANNELS; c++) begin
            if (i_rst) o_chan_ua[c*CUR_W +: CUR_W] <= '0;
            else if (i_upper[c]) o_chan_ua[c*CUR_W +: CUR_W] <= o_chan_ua[c*CUR_W +: CUR_W] + STEP;
            else if (i_lower[c] && o_chan_ua[c*CUR_W +: CUR_W] >= STEP)
                o_chan_ua[c*CUR_W +: CUR_W] <= o_chan_ua[c*CUR_W +: CUR_W] - STEP;
        end
    end
endmodule : ohs_drv_model

// [dv/tb.sv]
// Testbench for the hiccup sequencer: hiccup, retry latch, north-bridge and power-save paths.
// Assumes a shortened wait count and the driver model feeding the channel currents.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module tb;
    import ohs_pkg::*;
    localparam int unsigned WC = 20;
    logic                           clk = 1'b0;
    logic                           rst = 1'b1;
    logic                           en = 1'b1;
    logic                           psn = 1'b1;
    logic [CUR_W-1:0]               cavg = '0;
    logic [CUR_W-1:0]               navg = '0;
    logic [CUR_W-1:0]               peak = '0;
    logic [CUR_W*CORE_CHANNELS-1:0] chan;
    logic [CORE_CHANNELS-1:0]       up, lo;
    logic [1:0]                     oe;
    logic                           nup, nlo, pg, css, nss, lat, css_q, nss_q;
    int                             fails = 0, n_tests = 0, n_css = 0, n_nss = 0, b, b2, k;
    ohs_sequencer #(.WAIT_COUNT(WC)) i_dut (.i_ref_clk(clk), .i_rst(rst), .i_enable(en),
        .i_power_save_select_n(psn), .i_ext_phases_active(1'b1), .i_core_soft_done(1'b1),
        .i_nb_soft_done(1'b1), .i_core_avg_ua(cavg), .i_nb_avg_ua(navg), .i_chan_ua(chan),
        .i_core_pwm(4'hF), .i_nb_pwm(1'b1), .o_upper_gate_drive(up), .o_lower_gate_drive(lo),
        .o_nb_upper_gate_drive(nup), .o_nb_lower_gate_drive(nlo), .o_ext_pwm_oe(oe),
        .o_power_good_out(pg), .o_core_soft_start(css), .o_nb_soft_start(nss),
        .o_power_save_active(), .o_latched_off(lat));
    ohs_drv_model i_drv (.i_ref_clk(clk), .i_rst(rst), .i_upper(up), .i_lower(lo), .o_chan_ua(chan));
    initial forever #25 clk = ~clk;
    always @(posedge clk) begin
        css_q <= css;
        nss_q <= nss;
        if (css && !css_q) n_css++;
        if (nss && !nss_q) n_nss++;
        if (chan[CUR_W-1:0] > peak) peak <= chan[CUR_W-1:0];
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic boot();
        rst <= 1'b1;
        cyc(4);
        rst <= 1'b0;
    endtask : boot
    task automatic until_latch();
        for (k = 0; k < 400 && lat !== 1'b1; k++) cyc(1);
    endtask : until_latch
    initial begin
        #200_000;
        fails++;
        finish_test();
    end
    initial begin
        boot();
        cavg <= 12'h200;
        cyc(15 * WC);
        `CHK(n_css > 8, 1'b1)
        `CHK(lat, 1'b0)
        cavg <= '0;
        cyc(2 * WC);
        `CHK(oe, 2'b11)
        b = n_css;
        cavg <= 12'hFFF;
        until_latch();
        `CHK(n_css - b, 7)
        `CHK({up, lo, nup, nlo, pg}, 11'h000)
        `CHK(oe, 2'b00)
        cavg <= '0;
        en <= 1'b0;
        cyc(2);
        en <= 1'b1;
        cyc(3 * WC);
        `CHK({lat, css}, 2'b10)
        boot();
        cyc(2 * WC);
        b = n_nss;
        b2 = n_css;
        navg <= 12'hFFF;
        cyc(3);
        `CHK({nup, nlo, up[0] | lo[0]}, 3'b001)
        until_latch();
        `CHK(n_nss - b, 7)
        `CHK(n_css - b2, 0)
        `CHK({up, lo}, 8'h00)
        boot();
        b = n_css;
        navg <= '0;
        psn <= 1'b0;
        cavg <= 12'h080;
        cyc(5 * WC);
        `CHK(n_css - b > 2, 1'b1)
        for (k = 0; k < 100 && pg !== 1'b1; k++) cyc(1);
        cyc(2);
        en <= 1'b0;
        cyc(3 * WC);
        `CHK(css, 1'b0)
        `CHK(peak > OCL_REF_UA && peak <= 12'h0D2, 1'b1)
        finish_test();
    end
endmodule : tb
